/* inc/pps_cfg.svh */
// Purpose: timing constants for the projector power sequencer (host side)
// Assumes: 40 MHz clock, 25 ns period
// Notes:   counts derived from times; long counts become top parameters
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
`define PPS_CLK_HZ          40000000
`define PPS_T_CORE_LP_MS    100
`define PPS_T_RST_HOLD_MS   5
`define PPS_T_CLK_STABLE_MS 5
`define PPS_T_PARK_MS       20
`define PPS_T_SUPPLY_MS     50
`define PPS_T_FAST_US       32
`define PPS_T_SEQ_GAP_US    100
`define PPS_CYC_MS(t) ((t) * (`PPS_CLK_HZ / 1000))
`define PPS_CYC_US(t) ((t) * (`PPS_CLK_HZ / 1000000))
`define PPS_CNT_W           32
`endif

/* inc/pps_pkg.sv */
// Purpose: types for the projector power sequencer
// Assumes: nothing
// Notes:   one-hot state codes
`default_nettype none
package pps_pkg;
   typedef enum logic [8:0] {
      PPS_OFF      = 9'h001,
      PPS_CORE_ON  = 9'h002,
      PPS_LP_ON    = 9'h004,
      PPS_RST_HOLD = 9'h008,
      PPS_BOOT     = 9'h010,
      PPS_RUN      = 9'h020,
      PPS_PARK     = 9'h040,
      PPS_SUPPLY   = 9'h080,
      PPS_LP_OFF   = 9'h100
   } pps_state_type;
endpackage
`default_nettype wire

/* core/pps_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes:   output changes once stages two and three agree
`default_nettype none
module pps_sync
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic din,
   output var  logic dout
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         dout <= 1'b0;
      else if (s2_r == s3_r)
         dout <= s3_r;
   end
endmodule // pps_sync

/* core/pps_host_sequencer.sv */
// Purpose: host-side power manager and host processor for the display controller
// Assumes: single 40 MHz clock; pins from the controller are asynchronous
// Notes:   drives supplies, system reset, fast-park request and projector-on
//
// Functional notes
// - low-power supply after core, within 100ms
// - hold system reset 5ms after supplies
// - fast-park request high before reset release
// - reference clock stable within 5ms
// - no bus traffic until flag low
// - companion logic ready about 1.5s later
// - clock active to reset release under 1ms (code: clock starts with core, so over 5ms before reset release)
// - stop bus traffic before dropping projector-on
// - projector-on falling starts normal park
// - keep supplies and clock 20ms after
// - keep main supply 50ms after request falls
// - assert reset after park; flag pulled high
// - keep supplies 32us after fast-park request
// - keep projector-on until flag goes low
`default_nettype none
`include "pps_cfg.svh"
module pps_host_sequencer
#(
   parameter int unsigned RST_HOLD_CYC = `PPS_CYC_MS(`PPS_T_RST_HOLD_MS),
   parameter int unsigned CLK_STB_CYC  = `PPS_CYC_MS(`PPS_T_CLK_STABLE_MS),
   parameter int unsigned SEQ_GAP_CYC  = `PPS_CYC_US(`PPS_T_SEQ_GAP_US),
   parameter int unsigned PARK_CYC     = `PPS_CYC_MS(`PPS_T_PARK_MS),
   parameter int unsigned SUPPLY_CYC   = `PPS_CYC_MS(`PPS_T_SUPPLY_MS),
   parameter int unsigned FAST_CYC     = `PPS_CYC_US(`PPS_T_FAST_US)
)
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic power_request,
   input  wire logic supply_fault,
   input  wire logic init_flag,
   output var  logic main_system_supply,
   output var  logic core_supply,
   output var  logic low_power_core_supply,
   output var  logic ref_clock_enable,
   output var  logic system_reset_n,
   output var  logic fast_park_request_n,
   output var  logic projector_on_request,
   output var  logic bus_allowed,
   output var  logic powered_up,
   output var  logic fast_parked
);
   import pps_pkg::*;

   // ==========================================================
   // input synchronisation
   // ==========================================================
   logic flag_s;
   logic fault_s;
   logic req_s;
   pps_sync u_flag (.clk(clk), .resetn(resetn), .din(init_flag), .dout(flag_s));
   pps_sync u_fault (.clk(clk), .resetn(resetn), .din(supply_fault), .dout(fault_s));
   pps_sync u_req (.clk(clk), .resetn(resetn), .din(power_request), .dout(req_s));

   // ==========================================================
   // state and timer
   // ==========================================================
   pps_state_type           state_r;
   pps_state_type           state_nxt;
   logic [`PPS_CNT_W-1:0]   cnt_r;
   logic                    load;
   logic [`PPS_CNT_W-1:0]   load_val;
   logic                    done;
   logic                    flag_seen_hi_r;
   logic                    fast_r;
   logic [`PPS_CNT_W-1:0]   fast_cnt_r;

   assign done = (cnt_r == '0);

   always_comb
   begin
      state_nxt = state_r;
      load      = 1'b0;
      load_val  = '0;
      unique case (state_r)
         PPS_OFF:
            if (req_s && !fault_s)
            begin
               state_nxt = PPS_CORE_ON;
               load      = 1'b1;
               load_val  = `PPS_CNT_W'(SEQ_GAP_CYC);
            end
         PPS_CORE_ON:
            if (done)
            begin
               // low-power rail follows core well inside 100ms
               state_nxt = PPS_LP_ON;
               load      = 1'b1;
               // reset hold covers both the 5ms hold and clock settle
               load_val  = `PPS_CNT_W'((RST_HOLD_CYC > CLK_STB_CYC) ? RST_HOLD_CYC
                                                                      : CLK_STB_CYC);
            end
         PPS_LP_ON:
            state_nxt = PPS_RST_HOLD;
         PPS_RST_HOLD:
            // a late fault keeps reset low; park request must stand high first
            if (done && !fast_r && !fault_s && fast_park_request_n)
               state_nxt = PPS_BOOT;
         PPS_BOOT:
            // projector-on held until init done, even if requester drops
            if (flag_seen_hi_r && !flag_s)
               state_nxt = PPS_RUN;
         PPS_RUN:
            if (!req_s && !bus_allowed)
            begin
               state_nxt = PPS_PARK;
               load      = 1'b1;
               load_val  = `PPS_CNT_W'(PARK_CYC);
            end
         PPS_PARK:
            if (done)
            begin
               state_nxt = PPS_SUPPLY;
               load      = 1'b1;
               load_val  = `PPS_CNT_W'(SUPPLY_CYC - PARK_CYC);
            end
         PPS_SUPPLY:
            if (done)
            begin
               state_nxt = PPS_LP_OFF;
               load      = 1'b1;
               load_val  = `PPS_CNT_W'(SEQ_GAP_CYC);
            end
         PPS_LP_OFF:
            if (done)
               state_nxt = PPS_OFF;
         default:
            state_nxt = PPS_OFF;
      endcase
      // fault overrides any powered state once fast park window ends
      if (fast_r && fast_cnt_r == '0 && state_r != PPS_OFF)
      begin
         state_nxt = PPS_OFF;
         load      = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         state_r <= PPS_OFF;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt_r <= '0;
      else if (load)
         cnt_r <= load_val;
      else if (!done)
         cnt_r <= cnt_r - `PPS_CNT_W'(1);
   end

   // flag must be seen high before its fall counts as init done
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         flag_seen_hi_r <= 1'b0;
      else if (state_r != PPS_BOOT)
         flag_seen_hi_r <= 1'b0;
      else if (flag_s)
         flag_seen_hi_r <= 1'b1;
   end

   // ==========================================================
   // fast park on supply fault
   // ==========================================================
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fast_r     <= 1'b0;
         fast_cnt_r <= '0;
      end
      else if (!fast_r && fault_s && state_r != PPS_OFF && state_r != PPS_CORE_ON)
      begin
         fast_r     <= 1'b1;
         fast_cnt_r <= `PPS_CNT_W'(FAST_CYC);
      end
      else if (fast_r && fast_cnt_r != '0)
         fast_cnt_r <= fast_cnt_r - `PPS_CNT_W'(1);
      else if (fast_r && state_r == PPS_OFF && !fault_s)
         fast_r <= 1'b0;
   end

   // ==========================================================
   // pin drive
   // ==========================================================
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         main_system_supply    <= 1'b0;
         core_supply           <= 1'b0;
         low_power_core_supply <= 1'b0;
         ref_clock_enable      <= 1'b0;
      end
      else
      begin
         // supplies persist through the fast park window
         main_system_supply    <= (state_nxt != PPS_OFF);
         core_supply           <= (state_nxt != PPS_OFF);
         low_power_core_supply <= (state_nxt != PPS_OFF) && (state_nxt != PPS_CORE_ON)
                                  && (state_nxt != PPS_LP_OFF);
         ref_clock_enable      <= (state_nxt != PPS_OFF);
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         system_reset_n       <= 1'b0;
         fast_park_request_n  <= 1'b1;
         projector_on_request <= 1'b0;
      end
      else
      begin
         system_reset_n       <= (state_nxt == PPS_BOOT) || (state_nxt == PPS_RUN)
                                 || (state_nxt == PPS_PARK);
         // park request stays high unless a fault is seen, so it stands high before reset release
         fast_park_request_n  <= !(fast_r || (fault_s && state_r != PPS_OFF));
         projector_on_request <= (state_nxt == PPS_BOOT) || (state_nxt == PPS_RUN);
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bus_allowed <= 1'b0;
         powered_up  <= 1'b0;
         fast_parked <= 1'b0;
      end
      else
      begin
         // bus closed one cycle before projector-on falls in normal park; in fast park it closes FAST cycles before
         bus_allowed <= (state_nxt == PPS_RUN) && req_s && !fast_r;
         powered_up  <= (state_nxt == PPS_RUN);
         fast_parked <= fast_r;
      end
   end
endmodule // pps_host_sequencer
`default_nettype wire

/* tb/pps_host_sequencer_properties.sv */
// Purpose: port checker for pps_host_sequencer
// Assumes: small counts 10,10,4,20,40,8
// Notes:   bound to the design after the module
`default_nettype none
module pps_host_sequencer_chk
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic init_flag,
   input wire logic main_system_supply,
   input wire logic core_supply,
   input wire logic low_power_core_supply,
   input wire logic ref_clock_enable,
   input wire logic system_reset_n,
   input wire logic fast_park_request_n,
   input wire logic projector_on_request,
   input wire logic bus_allowed
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========
   // sequencing
   lp_after_core_a: assert property (low_power_core_supply |-> core_supply)
      else $error("low-power supply on without core");
   park_release_a: assert property ($rose(system_reset_n) |-> fast_park_request_n
      && $past(fast_park_request_n) && ref_clock_enable)
      else $error("reset released with park low or no clock");
   reset_hold_a: assert property ($rose(system_reset_n) |->
      $past(low_power_core_supply, 10)) else $error("reset released too early");
   // bus must already be closed the cycle before projector-on drops
   bus_drop_a: assert property ($fell(projector_on_request) |-> !bus_allowed
      && !$past(bus_allowed)) else $error("bus still allowed at projector-on fall");
   park_hold_a: assert property ($fell(projector_on_request) && fast_park_request_n
      |-> (core_supply && ref_clock_enable && main_system_supply && system_reset_n)[*8])
      else $error("supplies dropped during normal park");
   fast_hold_a: assert property ($fell(fast_park_request_n) |->
      (core_supply && ref_clock_enable)[*7]) else $error("supplies dropped in fast park");
   bus_flag_a: assert property (bus_allowed |-> !init_flag && system_reset_n)
      else $error("bus allowed before init done");
   reset_after_a: assert property ($fell(projector_on_request) && fast_park_request_n
      |-> ##[18:30] !system_reset_n) else $error("reset not asserted after park");
endmodule // pps_host_sequencer_chk
bind pps_host_sequencer pps_host_sequencer_chk i_chk (.clk(clk), .resetn(resetn),
   .init_flag(init_flag), .main_system_supply(main_system_supply),
   .core_supply(core_supply), .low_power_core_supply(low_power_core_supply),
   .ref_clock_enable(ref_clock_enable), .system_reset_n(system_reset_n),
   .fast_park_request_n(fast_park_request_n),
   .projector_on_request(projector_on_request), .bus_allowed(bus_allowed));
`default_nettype wire

/* tb/pps_ctrl_model.sv */
// Purpose: display controller model seen by the host sequencer
// Assumes: flag pin pulled high when not driven
// Notes:   boot length set by bench, slow or prompt
`default_nettype none
module pps_ctrl_model
(
   input  wire logic       clk,
   input  wire logic       core_supply,
   input  wire logic       system_reset_n,
   input  wire logic       fast_park_request_n,
   input  wire logic       projector_on_request,
   input  wire logic [7:0] boot_len,
   output var  logic       init_flag,
   output var  logic       mirror_parked
);
   logic [7:0] boot_r;
   logic       drive_r;
   logic       parking_r;
   logic [4:0] park_cnt_r;
   always_ff @(posedge clk)
   begin
      if (!system_reset_n || !core_supply)
      begin
         boot_r  <= 8'h00;
         drive_r <= 1'b0;
      end
      else
      begin
         drive_r <= 1'b1;
         // boot length stands for the whole boot, companion setup included
         if (boot_r < boot_len)
            boot_r <= boot_r + 8'h01;
      end
   end
   // pins registered before use, as the real part synchronises them
   always_ff @(posedge clk)
      parking_r <= system_reset_n && (!projector_on_request || !fast_park_request_n);
   // mirrors settle after 16 park cycles; cleared only when core drops
   always_ff @(posedge clk)
   begin
      if (!core_supply)
      begin
         park_cnt_r    <= 5'h00;
         mirror_parked <= 1'b0;
      end
      else if (parking_r && park_cnt_r != 5'h10)
         park_cnt_r <= park_cnt_r + 5'h01;
      else if (parking_r)
         mirror_parked <= 1'b1;
   end
   // released pin reads the pull-up level
   always_comb
      init_flag = drive_r ? (boot_r < boot_len) : 1'b1;
endmodule // pps_ctrl_model
`default_nettype wire

/* tb/projector_power_sequencer_test.sv */
// Purpose: self-checking bench for pps_host_sequencer
// Assumes: counts shrunk to 10,10,4,20,40,8
// Notes:   random boot lengths from a fixed lfsr seed
`default_nettype none
module projector_power_sequencer_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int GAP = 4;
   localparam int HOLD = 10;
   localparam int PARK = 20;
   localparam int SUP = 40;
   localparam int FAST = 8;
   localparam int S_UP = 0;
   localparam int S_RST = 1;
   localparam int S_FLAG = 2;
   localparam int S_CORE = 3;
   localparam int S_PARK = 4;
   localparam int S_MAIN = 5;
   localparam int S_LP = 6;
   logic clk, resetn, power_request, supply_fault, init_flag, main_system_supply;
   logic core_supply, low_power_core_supply, ref_clock_enable, system_reset_n;
   logic fast_park_request_n, projector_on_request, bus_allowed, powered_up, fast_parked;
   logic mirror_parked, rdn_parked;
   logic [7:0]  boot_len;
   logic [31:0] lfsr;
   int n_fail, check_count, cyc, t_core, t_lp, t_rup, t_pdn, t_rdn, t_mdn, t_fdn, t_cdn, t_old;
   pps_host_sequencer #(.RST_HOLD_CYC(HOLD), .CLK_STB_CYC(HOLD), .SEQ_GAP_CYC(GAP),
      .PARK_CYC(PARK), .SUPPLY_CYC(SUP), .FAST_CYC(FAST)) i_dut (.clk, .resetn,
      .power_request, .supply_fault, .init_flag, .main_system_supply, .core_supply,
      .low_power_core_supply, .ref_clock_enable, .system_reset_n, .fast_park_request_n,
      .projector_on_request, .bus_allowed, .powered_up, .fast_parked);
   pps_ctrl_model i_ctrl (.clk, .core_supply, .system_reset_n, .fast_park_request_n,
      .projector_on_request, .boot_len, .init_flag, .mirror_parked);
   // ==========
   // helpers
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int gap_after(input int a, input int b);
      return (a > b) ? a : b;
   endfunction
   task automatic check(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait; time-out shows as a mismatch
   // output chosen by sel, read fresh at every call
   function automatic logic pick(input int sel);
      case (sel)
         S_UP:    return powered_up;
         S_RST:   return system_reset_n;
         S_FLAG:  return init_flag;
         S_CORE:  return core_supply;
         S_PARK:  return fast_park_request_n;
         S_MAIN:  return main_system_supply;
         default: return low_power_core_supply;
      endcase
   endfunction
   task automatic wait_sig(input int sel, input logic v);
      int n;
      n = 0;
      while (pick(sel) !== v && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      check(pick(sel), v);
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========
   // clock, edge stamps, watchdog
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) cyc++;
   always @(posedge core_supply) t_core = cyc;
   always @(posedge low_power_core_supply) t_lp = cyc;
   always @(posedge system_reset_n) t_rup = cyc;
   always @(negedge projector_on_request) t_pdn = cyc;
   // park state is long settled here, so no race with the reset edge
   always @(negedge system_reset_n)
   begin
      t_rdn = cyc;
      rdn_parked = mirror_parked;
   end
   always @(negedge main_system_supply) t_mdn = cyc;
   always @(negedge fast_park_request_n) t_fdn = cyc;
   always @(negedge core_supply) t_cdn = cyc;
   initial
   begin
      repeat (6000) @(posedge clk);
      n_fail++;
      conclude();
   end
   // ==========
   // main sequence
   initial
   begin
      lfsr = 32'h0000_78ca;
      resetn = 1'b0;
      power_request = 1'b0;
      supply_fault = 1'b0;
      boot_len = 8'h05;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      supply_fault = 1'b1;
      power_request = 1'b1;
      repeat (20) @(negedge clk);
      check(core_supply, 1'b0);
      supply_fault = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         lfsr = next_rand(lfsr);
         boot_len = {2'b00, lfsr[5:0]} + 8'h01;
         power_request = 1'b1;
         if (i == 1)
         begin
            wait_sig(S_RST, 1'b1);
            power_request = 1'b0;
            wait_sig(S_FLAG, 1'b0);
            check(projector_on_request, 1'b1);
         end
         else
         begin
            wait_sig(S_UP, 1'b1);
            check(bus_allowed, 1'b1);
            check(t_lp - t_core >= GAP, 1'b1);
            check(t_rup - t_lp >= gap_after(HOLD, HOLD), 1'b1);
         end
         if (i == 2)
         begin
            supply_fault = 1'b1;
            wait_sig(S_CORE, 1'b0);
            check(t_cdn - t_fdn >= FAST, 1'b1);
            check(fast_park_request_n, 1'b0);
            check(fast_parked, 1'b1);
            supply_fault = 1'b0;
            wait_sig(S_PARK, 1'b1);
            check(fast_parked, 1'b0);
         end
         else
         begin
            power_request = 1'b0;
            wait_sig(S_MAIN, 1'b0);
            check(t_rdn - t_pdn >= PARK, 1'b1);
            check(rdn_parked, 1'b1);
            check(t_mdn - t_pdn >= SUP, 1'b1);
            check(low_power_core_supply, 1'b0);
         end
      end
      // corner: fault lands late in reset hold, reset must stay low
      t_old = t_rup;
      wait_sig(S_LP, 1'b1);
      lfsr = next_rand(lfsr);
      repeat ({1'b0, lfsr[1:0]} + 3'd3) @(negedge clk);
      supply_fault = 1'b1;
      wait_sig(S_CORE, 1'b0);
      check(t_rup == t_old, 1'b1);
      check(system_reset_n, 1'b0);
      conclude();
   end
endmodule // projector_power_sequencer_test
`default_nettype wire
